// [common/relay_scan_pkg.sv]
// shared constants for the relay matrix scan and status block
package relay_scan_pkg;
  // command opcodes
  localparam int           OP_W           = 5;
  localparam logic [4:0]   OP_SCAN_CLEAR  = 5'h01;
  localparam logic [4:0]   OP_SCAN_ADD    = 5'h02;
  localparam logic [4:0]   OP_SCAN_RANGE  = 5'h03;
  localparam logic [4:0]   OP_SCAN_COMMIT = 5'h04;
  localparam logic [4:0]   OP_INIT        = 5'h05;
  localparam logic [4:0]   OP_TRIG        = 5'h06;
  localparam logic [4:0]   OP_ABORT       = 5'h07;
  localparam logic [4:0]   OP_RESET       = 5'h08;
  localparam logic [4:0]   OP_CPON        = 5'h09;
  localparam logic [4:0]   OP_PRESET      = 5'h0a;
  localparam logic [4:0]   OP_OPER_ENAB_W = 5'h0b;
  localparam logic [4:0]   OP_OPER_ENAB_R = 5'h0c;
  localparam logic [4:0]   OP_OPER_EVT_R  = 5'h0d;
  localparam logic [4:0]   OP_OPER_COND_R = 5'h0e;
  localparam logic [4:0]   OP_STB_R       = 5'h0f;
  localparam logic [4:0]   OP_ESE_W       = 5'h10;
  localparam logic [4:0]   OP_ESE_R       = 5'h11;
  localparam logic [4:0]   OP_CDES        = 5'h12;
  localparam logic [4:0]   OP_CTYPE       = 5'h13;
  localparam logic [4:0]   OP_TRIG_SRC    = 5'h14;
  localparam logic [4:0]   OP_OUTP        = 5'h15;
  // trigger sources, low three bits of the argument
  localparam logic [2:0]   SRC_BUS        = 3'h0;
  localparam logic [2:0]   SRC_EXT        = 3'h1;
  localparam logic [2:0]   SRC_HOLD       = 3'h2;
  localparam logic [2:0]   SRC_IMM        = 3'h3;
  localparam logic [2:0]   SRC_TTL        = 3'h4;
  localparam int           TTL_LSB        = 3;
  // channel code layout: card, row, column
  localparam int           CARD_W         = 7;
  localparam int           ROW_W          = 4;
  localparam int           COL_W          = 6;
  localparam int           CH_W           = CARD_W + ROW_W + COL_W;
  localparam logic [6:0]   CARD_MIN       = 7'h01;
  localparam logic [6:0]   CARD_MAX       = 7'h63;
  localparam logic [6:0]   CARD_ALL       = 7'h00;
  // matrix variants
  localparam int           VAR_16X16      = 0;
  localparam int           VAR_4X64       = 1;
  localparam int           VAR_8X32       = 2;
  localparam logic [15:0]  DESC_16X16     = 16'h1010;
  localparam logic [15:0]  DESC_4X64      = 16'h0440;
  localparam logic [15:0]  DESC_8X32      = 16'h0820;
  localparam logic [3:0]   SERIAL_FIELD   = 4'h0;
  // status bit positions and reset values
  localparam int           OPER_SCAN_BIT  = 8;
  localparam int           STB_OPR_BIT    = 7;
  localparam int           STB_RQS_BIT    = 6;
  localparam int           STB_ESB_BIT    = 5;
  localparam int           STB_MAV_BIT    = 4;
  localparam int           STB_QUE_BIT    = 3;
  localparam logic [15:0]  MASK_RESET     = 16'h0000;

  function automatic logic [3:0] row_max(input int variant);
    case (variant)
      VAR_4X64: row_max = 4'h3;
      VAR_8X32: row_max = 4'h7;
      default:  row_max = 4'hf;
    endcase
  endfunction

  function automatic logic [5:0] col_max(input int variant);
    case (variant)
      VAR_4X64: col_max = 6'h3f;
      VAR_8X32: col_max = 6'h1f;
      default:  col_max = 6'h0f;
    endcase
  endfunction
endpackage

// [design/relay_chan_check.sv]
// channel code range check for one matrix variant
module relay_chan_check
  import relay_scan_pkg::*;
#(
  parameter int VARIANT = VAR_16X16
) (
  input  wire logic [CARD_W-1:0] card_i,
  input  wire logic [ROW_W-1:0]  row_i,
  input  wire logic [COL_W-1:0]  col_i,
  output logic                   ok_o
);
  // card 1..99, row and column within the variant geometry
  assign ok_o = (card_i >= CARD_MIN) && (card_i <= CARD_MAX) &&
                (row_i <= row_max(VARIANT)) && (col_i <= col_max(VARIANT));
endmodule

// [design/relay_matrix_scan_status.sv]
// scan list sequencer and operation status block of a relay matrix switchbox
// Functional notes
// - check card, row and column of entries
// - invalid list raises error, not accepted
// - singles, ranges and mixtures accepted
// - initiate closes first listed channel
// - selected trigger advances to next channel
// - final trigger opens the last channel
// - reset command opens every channel
// - card power-on opens one or all cards
// - scan finish sets event bit 8
// - condition register never shows bit 8
// - event and mask bit 8 set bit 7
// - enable mask reads back as written
// - event read returns 256 or 0, clears
// - abort leaves scan event bit clear
// - preset clears enable mask only
// - status byte summary bits at 7..3
// - standard event mask selects summary bits
// - description query returns matrix geometry
// - type query returns identity, serial zero
// - trigger from one selectable source
// - trigger output pulses on each closure
module relay_matrix_scan_status
  import relay_scan_pkg::*;
#(
  parameter int         VARIANT    = VAR_16X16,
  parameter int         LIST_DEPTH = 8,
  parameter logic [7:0] MODEL_ID   = 8'h5a,  // arbitrary value
  parameter logic [3:0] REV_ID     = 4'h1    // arbitrary value
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              CMD_VALID_I,
  input  wire logic [OP_W-1:0]   CMD_OP_I,
  input  wire logic [15:0]       CMD_ARG_I,
  input  wire logic [CARD_W-1:0] CMD_CARD_I,
  input  wire logic [ROW_W-1:0]  CMD_ROW_I,
  input  wire logic [COL_W-1:0]  CMD_COL_I,
  input  wire logic              BUS_TRG_I,
  input  wire logic              EXT_TRIG_I,
  input  wire logic [7:0]        TTL_TRIG_I,
  input  wire logic [15:0]       ESR_I,
  input  wire logic              MAV_I,
  input  wire logic              QUE_I,
  input  wire logic              RQS_I,
  output logic                   RESP_VALID_O,
  output logic [15:0]            RESP_DATA_O,
  output logic                   ERROR_O,
  output logic                   CHAN_CLOSED_O,
  output logic [CARD_W-1:0]      CHAN_CARD_O,
  output logic [ROW_W-1:0]       CHAN_ROW_O,
  output logic [COL_W-1:0]       CHAN_COL_O,
  output logic                   OPEN_CARD_O,
  output logic [CARD_W-1:0]      OPEN_CARD_NUM_O,
  output logic                   TRIG_OUT_O,
  output logic                   SCAN_BUSY_O,
  output logic [7:0]             STB_O
);
  localparam int IW = $clog2(LIST_DEPTH);
  localparam int CW = IW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(LIST_DEPTH);

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SCAN = 2'b10} seq_state_t;

  seq_state_t          state_q;
  logic [CH_W-1:0]     stg_start_q [LIST_DEPTH];
  logic [CH_W-1:0]     stg_end_q   [LIST_DEPTH];
  logic [CH_W-1:0]     act_start_q [LIST_DEPTH];
  logic [CH_W-1:0]     act_end_q   [LIST_DEPTH];
  logic [CW-1:0]       stg_cnt_q, act_cnt_q;
  logic                stg_bad_q;
  logic [IW-1:0]       idx_q;
  logic [CH_W-1:0]     cur_q;
  logic                closed_q, evt_q, trig_out_q, err_q;
  logic                open_card_q, resp_valid_q;
  logic [CARD_W-1:0]   open_num_q;
  logic [15:0]         mask_q, ese_q, resp_q;
  logic [2:0]          src_q, ttl_q;
  logic                outp_en_q;
  logic [7:0]          stb_q;
  logic                ch_ok, card_ok;
  logic [CH_W-1:0]     cmd_ch;

  // command decode helpers
  function automatic logic is_op(input logic [OP_W-1:0] op);
    is_op = CMD_VALID_I && (CMD_OP_I == op);
  endfunction

  // step one channel: column, then row, then card
  function automatic logic [CH_W-1:0] next_ch(input logic [CH_W-1:0] ch);
    logic [CARD_W-1:0] c;
    logic [ROW_W-1:0]  r;
    logic [COL_W-1:0]  k;
    {c, r, k} = ch;
    if (k != col_max(VARIANT)) begin
      k = k + 6'h01;
    end else begin
      k = '0;
      if (r != row_max(VARIANT)) begin
        r = r + 4'h1;
      end else begin
        r = '0;
        c = c + 7'h01;
      end
    end
    next_ch = {c, r, k};
  endfunction

  assign cmd_ch  = {CMD_CARD_I, CMD_ROW_I, CMD_COL_I};
  assign card_ok = (CMD_ARG_I[CARD_W-1:0] >= CARD_MIN) &&
                   (CMD_ARG_I[CARD_W-1:0] <= CARD_MAX) && (CMD_ARG_I[15:CARD_W] == '0);

  relay_chan_check #(.VARIANT(VARIANT)) i_relay_chan_check (
    .card_i (CMD_CARD_I),
    .row_i  (CMD_ROW_I),
    .col_i  (CMD_COL_I),
    .ok_o   (ch_ok)
  );

  // trigger selection and scan step decisions
  logic sw_trig, fire, at_last, scan_done, init_ok, abort_now, cpon_hit, rst_cmd;
  assign sw_trig   = is_op(OP_TRIG) && ((src_q == SRC_BUS) || (src_q == SRC_HOLD));
  always_comb begin
    case (src_q)
      SRC_BUS:  fire = sw_trig || BUS_TRG_I;
      SRC_EXT:  fire = EXT_TRIG_I;
      SRC_HOLD: fire = sw_trig;
      SRC_IMM:  fire = 1'b1;
      SRC_TTL:  fire = TTL_TRIG_I[ttl_q];
      default:  fire = 1'b0;
    endcase
  end
  assign rst_cmd   = is_op(OP_RESET);
  assign cpon_hit  = is_op(OP_CPON) &&
                     ((CMD_ARG_I[CARD_W-1:0] == CARD_ALL) ||
                      (CMD_ARG_I[CARD_W-1:0] == cur_q[CH_W-1 -: CARD_W]));
  assign abort_now = (state_q == ST_SCAN) && (is_op(OP_ABORT) || rst_cmd || cpon_hit);
  assign at_last   = (CW'(idx_q) == act_cnt_q - 1'b1) && (cur_q == act_end_q[idx_q]);
  assign scan_done = (state_q == ST_SCAN) && !abort_now && fire && at_last;
  assign init_ok   = is_op(OP_INIT) && (state_q == ST_IDLE) && (act_cnt_q != '0);

  // staging list: entries collected, any bad entry poisons the list
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stg_cnt_q <= '0;
      stg_bad_q <= 1'b0;
      for (int i = 0; i < LIST_DEPTH; i++) begin
        stg_start_q[i] <= '0;
        stg_end_q[i]   <= '0;
      end
    end else if (is_op(OP_SCAN_CLEAR) || is_op(OP_SCAN_COMMIT)) begin
      stg_cnt_q <= '0;
      stg_bad_q <= 1'b0;
    end else if (is_op(OP_SCAN_ADD)) begin
      if (!ch_ok || stg_cnt_q == DEPTH_C) begin
        stg_bad_q <= 1'b1;
      end else begin
        stg_start_q[stg_cnt_q[IW-1:0]] <= cmd_ch;
        stg_end_q[stg_cnt_q[IW-1:0]]   <= cmd_ch;
        stg_cnt_q                      <= stg_cnt_q + 1'b1;
      end
    end else if (is_op(OP_SCAN_RANGE)) begin
      // a range end must follow a start and not lie below it
      if (!ch_ok || stg_cnt_q == '0 ||
          cmd_ch < stg_start_q[IW'(stg_cnt_q - 1'b1)]) begin
        stg_bad_q <= 1'b1;
      end else begin
        stg_end_q[IW'(stg_cnt_q - 1'b1)] <= cmd_ch;
      end
    end
  end

  // active list: replaced only by a clean commit while idle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      act_cnt_q <= '0;
      for (int i = 0; i < LIST_DEPTH; i++) begin
        act_start_q[i] <= '0;
        act_end_q[i]   <= '0;
      end
    end else if (is_op(OP_SCAN_COMMIT) && !stg_bad_q && stg_cnt_q != '0 &&
                 state_q == ST_IDLE) begin
      act_cnt_q   <= stg_cnt_q;
      act_start_q <= stg_start_q;
      act_end_q   <= stg_end_q;
    end
  end

  // scan sequencer: one closed channel at a time
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q  <= ST_IDLE;
      idx_q    <= '0;
      cur_q    <= '0;
      closed_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (init_ok) begin
            state_q  <= ST_SCAN;
            idx_q    <= '0;
            cur_q    <= act_start_q[0];
            closed_q <= 1'b1;
          end
        end
        ST_SCAN: begin
          if (abort_now) begin
            state_q  <= ST_IDLE;
            closed_q <= 1'b0;
          end else if (fire && at_last) begin
            state_q  <= ST_IDLE;
            closed_q <= 1'b0;
          end else if (fire && cur_q == act_end_q[idx_q]) begin
            idx_q <= idx_q + 1'b1;
            cur_q <= act_start_q[idx_q + 1'b1];
          end else if (fire) begin
            cur_q <= next_ch(cur_q);
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          closed_q <= 1'b0;
        end
      endcase
    end
  end

  // card open strobe: card 0 means every card
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      open_card_q <= 1'b0;
      open_num_q  <= CARD_ALL;
    end else begin
      open_card_q <= rst_cmd || (is_op(OP_CPON) &&
                     (card_ok || CMD_ARG_I == 16'h0000));
      open_num_q  <= rst_cmd ? CARD_ALL : CMD_ARG_I[CARD_W-1:0];
    end
  end

  // trigger source and output enable; reset command restores immediate
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      src_q     <= SRC_IMM;
      ttl_q     <= '0;
      outp_en_q <= 1'b0;
    end else begin
      if (rst_cmd) begin
        src_q <= SRC_IMM;
      end else if (is_op(OP_TRIG_SRC) && CMD_ARG_I[2:0] <= SRC_TTL) begin
        src_q <= CMD_ARG_I[2:0];
        ttl_q <= CMD_ARG_I[TTL_LSB +: 3];
      end
      if (is_op(OP_OUTP)) begin
        outp_en_q <= CMD_ARG_I[0];
      end
    end
  end

  // pulse on every closure, but not on the final opening step
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trig_out_q <= 1'b0;
    end else begin
      trig_out_q <= outp_en_q && (init_ok ||
                    (state_q == ST_SCAN && !abort_now && fire && !at_last));
    end
  end

  // scan-complete event; a finishing scan beats a clearing read
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      evt_q <= 1'b0;
    end else if (scan_done) begin
      evt_q <= 1'b1;
    end else if (is_op(OP_OPER_EVT_R)) begin
      evt_q <= 1'b0;
    end
  end

  // enable masks
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mask_q <= MASK_RESET;
      ese_q  <= MASK_RESET;
    end else begin
      if (is_op(OP_PRESET)) begin
        mask_q <= MASK_RESET;
      end else if (is_op(OP_OPER_ENAB_W)) begin
        mask_q <= CMD_ARG_I;
      end
      if (is_op(OP_ESE_W)) begin
        ese_q <= CMD_ARG_I;
      end
    end
  end

  // status byte summary, refreshed every cycle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stb_q <= 8'h00;
    end else begin
      stb_q <= '0;
      stb_q[STB_OPR_BIT] <= evt_q && mask_q[OPER_SCAN_BIT];
      stb_q[STB_RQS_BIT] <= RQS_I;
      stb_q[STB_ESB_BIT] <= |(ESR_I & ese_q);
      stb_q[STB_MAV_BIT] <= MAV_I;
      stb_q[STB_QUE_BIT] <= QUE_I;
    end
  end

  // query answers, one cycle after the command
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      resp_valid_q <= 1'b0;
      resp_q       <= 16'h0000;
    end else begin
      resp_valid_q <= 1'b0;
      if (CMD_VALID_I) begin
        resp_valid_q <= 1'b1;
        case (CMD_OP_I)
          OP_OPER_ENAB_R: resp_q <= mask_q;
          OP_OPER_EVT_R:  resp_q <= 16'(evt_q) << OPER_SCAN_BIT;
          OP_OPER_COND_R: resp_q <= 16'h0000;
          OP_STB_R:       resp_q <= {8'h00, stb_q};
          OP_ESE_R:       resp_q <= ese_q;
          OP_CDES: begin
            resp_valid_q <= card_ok;
            resp_q <= (VARIANT == VAR_4X64) ? DESC_4X64 :
                      (VARIANT == VAR_8X32) ? DESC_8X32 : DESC_16X16;
          end
          OP_CTYPE: begin
            resp_valid_q <= card_ok;
            resp_q       <= {MODEL_ID, SERIAL_FIELD, REV_ID};
          end
          default:        resp_valid_q <= 1'b0;
        endcase
      end
    end
  end

  // error strobe for refused commands
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      err_q <= 1'b0;
    end else begin
      err_q <= (is_op(OP_SCAN_COMMIT) &&
                (stg_bad_q || stg_cnt_q == '0 || state_q != ST_IDLE)) ||
               (is_op(OP_INIT) && !init_ok) ||
               (is_op(OP_TRIG) && (state_q != ST_SCAN || !sw_trig)) ||
               ((is_op(OP_CDES) || is_op(OP_CTYPE)) && !card_ok) ||
               (is_op(OP_CPON) && !card_ok && CMD_ARG_I != 16'h0000);
    end
  end

  assign RESP_VALID_O    = resp_valid_q;
  assign RESP_DATA_O     = resp_q;
  assign ERROR_O         = err_q;
  assign CHAN_CLOSED_O   = closed_q;
  assign {CHAN_CARD_O, CHAN_ROW_O, CHAN_COL_O} = cur_q;
  assign OPEN_CARD_O     = open_card_q;
  assign OPEN_CARD_NUM_O = open_num_q;
  assign TRIG_OUT_O      = trig_out_q;
  assign SCAN_BUSY_O     = state_q[1];  // one-hot scan bit, straight from the state flop
  assign STB_O           = stb_q;

  // checks
  sequence s_init;
    init_ok;
  endsequence
  sequence s_first_closed;
    closed_q && cur_q == act_start_q[0];
  endsequence
  AST_INIT_CLOSE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_init |=> s_first_closed) else $error("initiate did not close first channel");
  AST_LAST_OPEN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    scan_done |=> !closed_q && state_q == ST_IDLE) else $error("last channel not opened");
  AST_EVT_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    scan_done |=> evt_q) else $error("scan done did not set event");
  AST_COND_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    is_op(OP_OPER_COND_R) |=> resp_valid_q && resp_q == 16'h0000)
    else $error("condition read not zero");
  AST_OPR_SUM: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    evt_q && mask_q[OPER_SCAN_BIT] |=> stb_q[STB_OPR_BIT]) else $error("OPR bit missing");
  AST_MASK_RB: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    is_op(OP_OPER_ENAB_W) ##1 !CMD_VALID_I ##1 is_op(OP_OPER_ENAB_R) |=>
    resp_q == $past(CMD_ARG_I, 3)) else $error("mask readback mismatch");
  AST_EVT_CLR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    is_op(OP_OPER_EVT_R) && !scan_done |=>
    !evt_q && resp_q == (16'($past(evt_q)) << OPER_SCAN_BIT))
    else $error("event read wrong");
  AST_ABORT_CLR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    abort_now && !evt_q |=> !evt_q) else $error("abort set scan event");
  AST_PRESET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    is_op(OP_PRESET) && !scan_done && !is_op(OP_OPER_EVT_R) |=> mask_q == '0 && $stable(evt_q))
    else $error("preset effect wrong");
  AST_BAD_LIST: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    is_op(OP_SCAN_COMMIT) && stg_bad_q |=> err_q && $stable(act_cnt_q))
    else $error("bad list accepted");
  AST_RST_OPEN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rst_cmd |=> !closed_q && open_card_q && open_num_q == CARD_ALL)
    else $error("reset left channel closed");
endmodule

// [verif/relay_host_model.sv]
// host controller model: issues commands and drives trigger and status lines
module relay_host_model
  import relay_scan_pkg::*;
(
  input  wire logic              clk_i,
  output logic                   cmd_valid_o,
  output logic [OP_W-1:0]        cmd_op_o,
  output logic [15:0]            cmd_arg_o,
  output logic [CARD_W-1:0]      cmd_card_o,
  output logic [ROW_W-1:0]       cmd_row_o,
  output logic [COL_W-1:0]       cmd_col_o,
  output logic                   bus_trg_o,
  output logic                   ext_trig_o,
  output logic [7:0]             ttl_trig_o,
  output logic [15:0]            esr_o,
  output logic                   mav_o,
  output logic                   que_o,
  output logic                   rqs_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 5'h00;
    cmd_arg_o = 16'h0000;
    {cmd_card_o, cmd_row_o, cmd_col_o} = '0;
    {bus_trg_o, ext_trig_o, ttl_trig_o} = '0;
    {esr_o, mav_o, que_o, rqs_o} = '0;
  end

  // one command per call, held over its taking edge; caller orders scan setup first
  task automatic send(input logic [4:0] op, input logic [15:0] arg, input logic [CH_W-1:0] ch);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_arg_o = arg;
    {cmd_card_o, cmd_row_o, cmd_col_o} = ch;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_arg_o = ~arg;  // stale argument never looks valid
  endtask

  // single high cycle on the chosen trigger inputs
  task automatic pulse_trig(input logic ext, input logic [7:0] ttl, input logic bus);
    @(posedge clk_i);
    #1;
    ext_trig_o = ext;
    ttl_trig_o = ttl;
    bus_trg_o = bus;
    @(posedge clk_i);
    #1;
    {bus_trg_o, ext_trig_o, ttl_trig_o} = '0;
  endtask

  // summary levels seen by the status byte
  task automatic set_status(input logic [15:0] esr, input logic mav, input logic que,
                            input logic rqs);
    esr_o = esr;
    mav_o = mav;
    que_o = que;
    rqs_o = rqs;
  endtask
endmodule

// [verif/tb_relay_matrix_scan_status.sv]
// self-checking bench for the relay scan sequencer and status block
module tb_relay_matrix_scan_status
  import relay_scan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MID = 8'h3c;  // arbitrary value
  localparam logic [3:0] RID = 4'h2;   // arbitrary value
  logic CLK_I, RST_N_I, CMD_VALID_I, BUS_TRG_I, EXT_TRIG_I, MAV_I, QUE_I, RQS_I;
  logic [OP_W-1:0] CMD_OP_I;
  logic [15:0] CMD_ARG_I, ESR_I, RESP_DATA_O;
  logic [CARD_W-1:0] CMD_CARD_I, CHAN_CARD_O, OPEN_CARD_NUM_O;
  logic [ROW_W-1:0] CMD_ROW_I, CHAN_ROW_O;
  logic [COL_W-1:0] CMD_COL_I, CHAN_COL_O;
  logic [7:0] TTL_TRIG_I, STB_O;
  logic RESP_VALID_O, ERROR_O, CHAN_CLOSED_O, OPEN_CARD_O, TRIG_OUT_O, SCAN_BUSY_O;
  int err_count = 0;
  int comparisons = 0;

  relay_matrix_scan_status #(.MODEL_ID(MID), .REV_ID(RID)) i_relay_matrix_scan_status (.*);
  relay_host_model i_relay_host_model (.clk_i(CLK_I), .cmd_valid_o(CMD_VALID_I),
    .cmd_op_o(CMD_OP_I), .cmd_arg_o(CMD_ARG_I), .cmd_card_o(CMD_CARD_I), .cmd_row_o(CMD_ROW_I),
    .cmd_col_o(CMD_COL_I), .bus_trg_o(BUS_TRG_I), .ext_trig_o(EXT_TRIG_I),
    .ttl_trig_o(TTL_TRIG_I), .esr_o(ESR_I), .mav_o(MAV_I), .que_o(QUE_I), .rqs_o(RQS_I));

  // 50 ns clock
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // short alias; outputs are sampled 1 ns after the taking edge
  task automatic cmd(input logic [4:0] op, input logic [15:0] arg, input logic [CH_W-1:0] ch);
    i_relay_host_model.send(op, arg, ch);
  endtask

  initial begin
    RST_N_I = 1'b0;
    repeat (6) @(posedge CLK_I);
    #1;
    RST_N_I = 1'b1;
    check("stb_rst", {8'h00, STB_O}, 16'h0000);
    check("busy_rst", {15'h0, SCAN_BUSY_O}, 16'h0000);
    // mask readback and preset
    cmd(OP_OPER_ENAB_W, 16'hffff, '0);
    cmd(OP_OPER_ENAB_R, 16'h0000, '0);
    check("enab", RESP_DATA_O, 16'hffff);
    cmd(OP_PRESET, 16'h0000, '0);
    cmd(OP_OPER_ENAB_R, 16'h0000, '0);
    check("enab_pre", RESP_DATA_O, 16'h0000);
    cmd(OP_OPER_ENAB_W, 16'h0100, '0);
    // range scan 1/0/0..1/0/1 on software trigger
    cmd(OP_TRIG_SRC, {13'h0, SRC_HOLD}, '0);
    cmd(OP_SCAN_CLEAR, 16'h0000, '0);
    cmd(OP_SCAN_ADD, 16'h0000, {7'h01, 4'h0, 6'h00});
    cmd(OP_SCAN_RANGE, 16'h0000, {7'h01, 4'h0, 6'h01});
    cmd(OP_SCAN_COMMIT, 16'h0000, '0);
    cmd(OP_INIT, 16'h0000, '0);
    check("closed", {15'h0, CHAN_CLOSED_O}, 16'h0001);
    check("ch0", {CHAN_CARD_O, 3'h0, CHAN_COL_O}, 16'h0200);
    cmd(OP_TRIG, 16'h0000, '0);
    check("ch1", {10'h0, CHAN_COL_O}, 16'h0001);
    cmd(OP_TRIG, 16'h0000, '0);
    check("opened", {14'h0, CHAN_CLOSED_O, SCAN_BUSY_O}, 16'h0000);
    cmd(OP_OPER_COND_R, 16'h0000, '0);
    check("cond", RESP_DATA_O, 16'h0000);
    check("opr", {15'h0, STB_O[7]}, 16'h0001);
    cmd(OP_OPER_EVT_R, 16'h0000, '0);
    check("evt", RESP_DATA_O, 16'h0100);
    cmd(OP_OPER_EVT_R, 16'h0000, '0);
    check("evt_clr", RESP_DATA_O, 16'h0000);
    cmd(OP_TRIG, 16'h0000, '0);
    check("trig_idle", {15'h0, ERROR_O}, 16'h0001);
    // external trigger, then abort mid-scan
    cmd(OP_TRIG_SRC, {13'h0, SRC_EXT}, '0);
    cmd(OP_INIT, 16'h0000, '0);
    i_relay_host_model.pulse_trig(1'b1, 8'h00, 1'b0);
    check("ext", {10'h0, CHAN_COL_O}, 16'h0001);
    cmd(OP_ABORT, 16'h0000, '0);
    cmd(OP_OPER_EVT_R, 16'h0000, '0);
    check("abort_evt", RESP_DATA_O, 16'h0000);
    // column 16 is beyond a 16x16 card
    cmd(OP_SCAN_CLEAR, 16'h0000, '0);
    cmd(OP_SCAN_ADD, 16'h0000, {7'h01, 4'h0, 6'h10});
    cmd(OP_SCAN_COMMIT, 16'h0000, '0);
    check("bad_list", {15'h0, ERROR_O}, 16'h0001);
    // unordered singles
    cmd(OP_SCAN_ADD, 16'h0000, {7'h02, 4'h3, 6'h04});
    cmd(OP_SCAN_ADD, 16'h0000, {7'h01, 4'h0, 6'h00});
    cmd(OP_SCAN_COMMIT, 16'h0000, '0);
    cmd(OP_TRIG_SRC, {13'h0, SRC_HOLD}, '0);
    cmd(OP_INIT, 16'h0000, '0);
    check("first", {CHAN_CARD_O, CHAN_ROW_O, CHAN_COL_O[4:0]}, 16'h0464);
    cmd(OP_TRIG, 16'h0000, '0);
    check("second", {CHAN_CARD_O, CHAN_ROW_O, CHAN_COL_O[4:0]}, 16'h0200);
    cmd(OP_RESET, 16'h0000, '0);
    check("rst_cmd", {14'h0, CHAN_CLOSED_O, SCAN_BUSY_O}, 16'h0000);
    cmd(OP_CPON, 16'h0005, '0);
    check("cpon", {8'h0, OPEN_CARD_O, OPEN_CARD_NUM_O}, 16'h0085);
    cmd(OP_CPON, 16'h0000, '0);
    check("cpon_all", {8'h0, OPEN_CARD_O, OPEN_CARD_NUM_O}, 16'h0080);
    // ttl line 2 steps, line 1 does not; a bus trigger ends the scan
    cmd(OP_TRIG_SRC, 16'h0014, '0);
    cmd(OP_INIT, 16'h0000, '0);
    i_relay_host_model.pulse_trig(1'b0, 8'h02, 1'b0);
    check("ttl_other", {9'h0, CHAN_CARD_O}, 16'h0002);
    i_relay_host_model.pulse_trig(1'b0, 8'h04, 1'b0);
    check("ttl_sel", {9'h0, CHAN_CARD_O}, 16'h0001);
    cmd(OP_TRIG_SRC, {13'h0, SRC_BUS}, '0);
    i_relay_host_model.pulse_trig(1'b0, 8'h00, 1'b1);
    check("bus_end", {14'h0, CHAN_CLOSED_O, SCAN_BUSY_O}, 16'h0000);
    cmd(OP_OPER_EVT_R, 16'h0000, '0);
    check("evt_vld", {RESP_VALID_O, RESP_DATA_O[14:0]}, 16'h8100);
    // immediate source runs the scan alone; trigger out on closures only
    cmd(OP_OUTP, 16'h0001, '0);
    cmd(OP_TRIG_SRC, {13'h0, SRC_IMM}, '0);
    cmd(OP_INIT, 16'h0000, '0);
    check("trig_out", {15'h0, TRIG_OUT_O}, 16'h0001);
    cmd(OP_OUTP, 16'h0000, '0);
    check("imm_end", {14'h0, TRIG_OUT_O, SCAN_BUSY_O}, 16'h0000);
    cmd(OP_OPER_EVT_R, 16'h0000, '0);
    check("evt_imm", RESP_DATA_O, 16'h0100);
    // card queries
    cmd(OP_CDES, 16'h0001, '0);
    check("cdes", RESP_DATA_O, DESC_16X16);
    cmd(OP_CTYPE, 16'h0001, '0);
    check("ctype", RESP_DATA_O, {MID, 4'h0, RID});
    // status byte summary bits
    i_relay_host_model.set_status(16'h0000, 1'b1, 1'b1, 1'b1);
    cmd(OP_STB_R, 16'h0000, '0);
    check("stb", {8'h0, STB_O}, 16'h0058);
    cmd(OP_ESE_W, 16'h0004, '0);
    i_relay_host_model.set_status(16'h0004, 1'b0, 1'b0, 1'b0);
    cmd(OP_ESE_R, 16'h0000, '0);
    check("ese", RESP_DATA_O, 16'h0004);
    check("esb", {8'h0, STB_O}, 16'h0020);
    test_done();
  end
endmodule
